// >>> design/hifl_pkg.sv
// Package: register map, field layout, reset values and carriers for the interrupt gate block
package hifl_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0]  OFF_IRQ_SOURCE_MASK   = 8'h5C;
   localparam logic [7:0]  OFF_BYTE_ORDER_PROBE  = 8'h64;
   localparam logic [7:0]  OFF_FIFO_LEVEL_THRESH = 8'h68;
   localparam logic [7:0]  OFF_RX_ENGINE_CONFIG  = 8'h6C;

   // ----------------------------------------------------------------
   // Reset values and writable masks
   // ----------------------------------------------------------------
   localparam logic [31:0] BYTE_ORDER_PATTERN    = 32'h8765_4321;
   localparam logic [31:0] IRQ_MASK_RST          = 32'h0000_0000;
   localparam logic [31:0] IRQ_MASK_WRITABLE     = 32'h83BF_EFFF;  // 30:26, 22 and 12 stay zero
   localparam logic [31:0] FIFO_THRESH_RST       = 32'h4800_0000;
   localparam logic [31:0] RX_CFG_RST            = 32'h0000_0000;
   localparam logic [31:0] RX_CFG_WRITABLE       = 32'hCFFF_0000;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int          TX_DATA_THR_LSB       = 24;
   localparam int          TX_STAT_THR_LSB       = 16;
   localparam int          RX_DATA_THR_LSB       = 8;
   localparam int          RX_STAT_THR_LSB       = 0;
   localparam int          ALIGN_LSB             = 30;
   localparam int          DMA_CNT_LSB           = 16;
   localparam int          DMA_CNT_W             = 12;

   // Status bit positions produced inside this block
   localparam int          BIT_RX_DMA_DONE       = 20;
   localparam int          BIT_TX_SPACE_AVAIL    = 9;
   localparam int          BIT_TX_STATUS_LEVEL   = 7;
   localparam int          BIT_RX_DATA_LEVEL     = 5;
   localparam int          BIT_RX_STATUS_LEVEL   = 3;

   // Pad masks in DWORDs for each end alignment
   localparam logic [3:0]  PAD_MASK_4B           = 4'h0;
   localparam logic [3:0]  PAD_MASK_16B          = 4'h3;
   localparam logic [3:0]  PAD_MASK_32B          = 4'h7;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ALIGN_4B, ALIGN_16B, ALIGN_32B, ALIGN_RSVD} hifl_align_e;

   // Live FIFO fill figures from the FIFO controllers
   typedef struct packed {
      logic [7:0] tx_data_free;   // 64-byte blocks
      logic [7:0] tx_stat_used;   // DWORDs
      logic [7:0] rx_data_free;   // 64-byte blocks
      logic [7:0] rx_stat_used;   // DWORDs
   } hifl_levels_s;

   // Level events raised here
   typedef struct packed {
      logic tx_space_avail_irq;
      logic tx_status_level_irq;
      logic rx_data_level_irq;
      logic rx_status_level_irq;
   } hifl_level_irq_s;

endpackage

// >>> design/hifl_irq_ctrl.sv
// Interrupt gate, FIFO level thresholds, byte order probe and receive config behind an APB slave

// Summary of operation
// - Enable bit set lets source drive request
// - Status follows source regardless of enable
// - Bits 31,25,24 gate; 30:26 read-only
// - Bits 23 and 6 gate; 22 reads zero
// - Bits 21,20 gate, read/write, reset zero
// - Bits 19,18,17 gate timer, PHY, power
// - Bits 16..13 gate overflow, watchdog, errors
// - Bits 11..9, 2..0 gate; 12 reserved
// - Bits 8,7,5,4,3 gate FIFO events
// - Byte order probe returns fixed pattern
// - Tx data threshold, raise when free exceeds
// - Tx status threshold, raise when used exceeds
// - Rx space threshold, raise when free below
// - Rx status threshold, raise when used exceeds
// - End alignment pads last transfer DWORDs
// - Alignment codes 4, 16, 32 bytes
// - Twelve-bit receive transfer countdown field
// - Countdown drops per DWORD; host may overwrite
module hifl_irq_ctrl
   import hifl_pkg::*;
(
   // Clock and reset
   input  wire logic            pclk,
   input  wire logic            presetn,
   // APB slave
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [7:0]      paddr,
   input  wire logic [31:0]     pwdata,
   output logic                 pready,
   output logic [31:0]          prdata,
   output logic                 pslverr,
   // Interrupt sources and FIFO figures
   input  wire logic [31:0]     irq_status_word,
   input  wire hifl_levels_s    fifo_levels,
   input  wire logic            rx_dword_read,
   input  wire logic [11:0]     rx_pkt_dwords,
   // Results
   output logic                 irq_request,
   output hifl_level_irq_s      level_irqs,
   output logic                 rx_dma_done,
   output logic [3:0]           rx_pad_dwords
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [31:0]           irq_source_mask_q;
   logic [31:0]           fifo_level_thresholds_q;
   logic [1:0]            rx_align_q;
   logic [DMA_CNT_W-1:0]  rx_transfer_countdown_q;
   logic                  pready_q;
   logic [31:0]           prdata_q;
   logic                  pslverr_q;
   logic                  irq_q;
   hifl_level_irq_s       level_q;
   logic                  dma_done_q;
   logic [3:0]            pad_q;

   logic                  access_ph;
   logic                  wr_commit;
   logic                  addr_hit;
   logic [31:0]           rd_mux;
   logic [31:0]           eff_status;
   logic [3:0]            pad_mask;
   hifl_align_e           align_sel;

   // Access is taken on the second access-phase edge; one wait state gives a clean registered read
   assign access_ph = psel && penable;
   assign wr_commit = access_ph && pready_q && pwrite;

   // ----------------------------------------------------------------
   // APB slave handshake
   // ----------------------------------------------------------------
   // Address decode for the four mapped words
   always_comb
   begin
      addr_hit = 1'b1;
      rd_mux   = 32'h0000_0000;
      case (paddr)
         OFF_IRQ_SOURCE_MASK:   rd_mux = irq_source_mask_q;
         OFF_BYTE_ORDER_PROBE:  rd_mux = BYTE_ORDER_PATTERN;
         OFF_FIFO_LEVEL_THRESH: rd_mux = fifo_level_thresholds_q;
         OFF_RX_ENGINE_CONFIG:  rd_mux = {rx_align_q, 2'b00, rx_transfer_countdown_q, 16'h0000};
         default:               addr_hit = 1'b0;
      endcase
   end

   // Ready rises one cycle into the access phase and drops right after completion
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pready_q  <= access_ph && !pready_q;
         pslverr_q <= access_ph && !pready_q && !addr_hit;   // Unmapped words answer with an error
         if (access_ph && !pready_q && !pwrite)
            prdata_q <= rd_mux;
         else
            prdata_q <= 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt enable register
   // ----------------------------------------------------------------
   // Reserved bits are masked so they can never be set by software
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_source_mask_q <= IRQ_MASK_RST;
      else if (wr_commit && paddr == OFF_IRQ_SOURCE_MASK)
         irq_source_mask_q <= pwdata & IRQ_MASK_WRITABLE;
   end

   // ----------------------------------------------------------------
   // FIFO level thresholds
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fifo_level_thresholds_q <= FIFO_THRESH_RST;
      else if (wr_commit && paddr == OFF_FIFO_LEVEL_THRESH)
         fifo_level_thresholds_q <= pwdata;
   end

   // Level comparisons, registered so downstream sees clean levels
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         level_q <= '0;
      else
      begin
         level_q.tx_space_avail_irq  <= fifo_levels.tx_data_free >
                                        fifo_level_thresholds_q[TX_DATA_THR_LSB +: 8];
         level_q.tx_status_level_irq <= fifo_levels.tx_stat_used >
                                        fifo_level_thresholds_q[TX_STAT_THR_LSB +: 8];
         level_q.rx_data_level_irq   <= fifo_levels.rx_data_free <
                                        fifo_level_thresholds_q[RX_DATA_THR_LSB +: 8];
         level_q.rx_status_level_irq <= fifo_levels.rx_stat_used >
                                        fifo_level_thresholds_q[RX_STAT_THR_LSB +: 8];
      end
   end

   // ----------------------------------------------------------------
   // Receive configuration: alignment and transfer countdown
   // ----------------------------------------------------------------
   // Alignment is only latched from the bus; the host keeps it steady mid-packet
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rx_align_q <= RX_CFG_RST[ALIGN_LSB +: 2];
      else if (wr_commit && paddr == OFF_RX_ENGINE_CONFIG)
         rx_align_q <= pwdata[ALIGN_LSB +: 2];
   end

   // A host write wins over a same-cycle decrement so a fresh count is never lost
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_transfer_countdown_q <= RX_CFG_RST[DMA_CNT_LSB +: DMA_CNT_W];
         dma_done_q              <= 1'b0;
      end
      else if (wr_commit && paddr == OFF_RX_ENGINE_CONFIG)
      begin
         rx_transfer_countdown_q <= pwdata[DMA_CNT_LSB +: DMA_CNT_W];
         dma_done_q              <= 1'b0;
      end
      else if (rx_dword_read && rx_transfer_countdown_q != '0)
      begin
         rx_transfer_countdown_q <= rx_transfer_countdown_q - 12'h001;
         dma_done_q              <= rx_transfer_countdown_q == 12'h001;
      end
      else
         dma_done_q <= 1'b0;
   end

   // Decode of the alignment code into a DWORD pad mask
   assign align_sel = hifl_align_e'(rx_align_q);
   always_comb
   begin
      case (align_sel)
         ALIGN_4B:  pad_mask = PAD_MASK_4B;
         ALIGN_16B: pad_mask = PAD_MASK_16B;
         ALIGN_32B: pad_mask = PAD_MASK_32B;
         default:   pad_mask = PAD_MASK_4B;    // Reserved code treated as no padding
      endcase
   end

   // Extra DWORDs needed to round the packet up to the alignment
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pad_q <= 4'h0;
      else
         pad_q <= (4'h0 - rx_pkt_dwords[3:0]) & pad_mask;
   end

   // ----------------------------------------------------------------
   // Request output
   // ----------------------------------------------------------------
   // Internally raised events join the external status; the enable only gates the pin
   always_comb
   begin
      eff_status                      = irq_status_word;
      eff_status[BIT_RX_DMA_DONE]     = irq_status_word[BIT_RX_DMA_DONE] | dma_done_q;
      eff_status[BIT_TX_SPACE_AVAIL]  = irq_status_word[BIT_TX_SPACE_AVAIL] | level_q.tx_space_avail_irq;
      eff_status[BIT_TX_STATUS_LEVEL] = irq_status_word[BIT_TX_STATUS_LEVEL] | level_q.tx_status_level_irq;
      eff_status[BIT_RX_DATA_LEVEL]   = irq_status_word[BIT_RX_DATA_LEVEL] | level_q.rx_data_level_irq;
      eff_status[BIT_RX_STATUS_LEVEL] = irq_status_word[BIT_RX_STATUS_LEVEL] | level_q.rx_status_level_irq;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_q <= 1'b0;
      else
         irq_q <= |(eff_status & irq_source_mask_q);
   end

   // Outputs straight from flops
   assign pready        = pready_q;
   assign prdata        = prdata_q;
   assign pslverr       = pslverr_q;
   assign irq_request   = irq_q;
   assign level_irqs    = level_q;
   assign rx_dma_done   = dma_done_q;
   assign rx_pad_dwords = pad_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_first_access;
      psel && penable && !pready_q;
   endsequence

   sequence s_mask_write;
      wr_commit && paddr == OFF_IRQ_SOURCE_MASK;
   endsequence

   property p_irq_follows;
      ##1 !$past(presetn) || irq_request == |($past(eff_status) & $past(irq_source_mask_q));
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("irq_request not gated status");

   property p_enable_raises;
      (irq_source_mask_q[31] && irq_status_word[31]) |=> irq_request;
   endproperty
   a_enable_raises: assert property (p_enable_raises) else $error("enabled source missed");

   property p_reserved_zero;
      (irq_source_mask_q & ~IRQ_MASK_WRITABLE) == 32'h0000_0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved enable bit set");

   property p_mask_write_lands;
      s_mask_write |=> irq_source_mask_q == ($past(pwdata) & IRQ_MASK_WRITABLE);
   endproperty
   a_mask_write_lands: assert property (p_mask_write_lands) else $error("enable write lost");

   property p_probe_read;
      (s_first_access and (!pwrite && paddr == OFF_BYTE_ORDER_PROBE)) |=>
         pready && prdata == BYTE_ORDER_PATTERN;
   endproperty
   a_probe_read: assert property (p_probe_read) else $error("byte order probe wrong");

   property p_tx_space;
      ##1 !$past(presetn) || level_irqs.tx_space_avail_irq ==
         ($past(fifo_levels.tx_data_free) > $past(fifo_level_thresholds_q[31:24]));
   endproperty
   a_tx_space: assert property (p_tx_space) else $error("tx space level wrong");

   property p_rx_space;
      ##1 !$past(presetn) || level_irqs.rx_data_level_irq ==
         ($past(fifo_levels.rx_data_free) < $past(fifo_level_thresholds_q[15:8]));
   endproperty
   a_rx_space: assert property (p_rx_space) else $error("rx space level wrong");

   property p_countdown_step;
      (rx_dword_read && rx_transfer_countdown_q != 12'h000 && !wr_commit) |=>
         rx_transfer_countdown_q == $past(rx_transfer_countdown_q) - 12'h001;
   endproperty
   a_countdown_step: assert property (p_countdown_step) else $error("countdown did not step");

   property p_dma_done;
      (rx_dword_read && rx_transfer_countdown_q == 12'h001 && !wr_commit) |=>
         rx_dma_done ##1 !rx_dma_done;
   endproperty
   a_dma_done: assert property (p_dma_done) else $error("transfer done pulse wrong");

   property p_pad_16;
      (rx_align_q == 2'b01 && rx_pkt_dwords[1:0] == 2'b01) |=> rx_pad_dwords == 4'h3;
   endproperty
   a_pad_16: assert property (p_pad_16) else $error("16-byte pad wrong");

   property p_ready_one;
      s_first_access |=> pready ##1 !pready;
   endproperty
   a_ready_one: assert property (p_ready_one) else $error("ready not one cycle");

   // Status level compares; the reset edge itself is excused because the flops were held
   property p_tx_status_level;
      ##1 !$past(presetn) || level_irqs.tx_status_level_irq ==
         ($past(fifo_levels.tx_stat_used) > $past(fifo_level_thresholds_q[TX_STAT_THR_LSB +: 8]));
   endproperty
   a_tx_status_level: assert property (p_tx_status_level) else $error("tx status level wrong");

   property p_rx_status_level;
      ##1 !$past(presetn) || level_irqs.rx_status_level_irq ==
         ($past(fifo_levels.rx_stat_used) > $past(fifo_level_thresholds_q[RX_STAT_THR_LSB +: 8]));
   endproperty
   a_rx_status_level: assert property (p_rx_status_level) else $error("rx status level wrong");

   property p_thresh_write;
      (wr_commit && paddr == OFF_FIFO_LEVEL_THRESH) |=> fifo_level_thresholds_q == $past(pwdata);
   endproperty
   a_thresh_write: assert property (p_thresh_write) else $error("threshold write lost");

   // Enable register only moves on a host write; with every gate shut the pin stays low
   property p_mask_hold;
      !(wr_commit && paddr == OFF_IRQ_SOURCE_MASK) |=> $stable(irq_source_mask_q);
   endproperty
   a_mask_hold: assert property (p_mask_hold) else $error("enable changed without write");

   property p_gate_off;
      (irq_source_mask_q == 32'h0000_0000) |=> !irq_request;
   endproperty
   a_gate_off: assert property (p_gate_off) else $error("request with all gates shut");

   // Receive configuration writes and the countdown between reads
   sequence s_cfg_write;
      wr_commit && paddr == OFF_RX_ENGINE_CONFIG;
   endsequence

   property p_count_load;
      s_cfg_write |=> rx_transfer_countdown_q == $past(pwdata[DMA_CNT_LSB +: DMA_CNT_W]);
   endproperty
   a_count_load: assert property (p_count_load) else $error("countdown overwrite lost");

   property p_count_hold;
      (!rx_dword_read && !wr_commit) |=> $stable(rx_transfer_countdown_q);
   endproperty
   a_count_hold: assert property (p_count_hold) else $error("countdown moved without read");

   property p_align_load;
      s_cfg_write |=> rx_align_q == $past(pwdata[ALIGN_LSB +: 2]);
   endproperty
   a_align_load: assert property (p_align_load) else $error("alignment write lost");

   property p_pad_4;
      (rx_align_q == 2'b00) |=> rx_pad_dwords == 4'h0;
   endproperty
   a_pad_4: assert property (p_pad_4) else $error("4-byte pad wrong");

   property p_pad_32;
      (rx_align_q == 2'b10 && rx_pkt_dwords[2:0] == 3'b001) |=> rx_pad_dwords == 4'h7;
   endproperty
   a_pad_32: assert property (p_pad_32) else $error("32-byte pad wrong");

endmodule

// >>> testbench/hifl_host_model.sv
// Host processor model: APB master that drives the register bus of the interrupt gate block
module hifl_host_model
   import hifl_pkg::*;
(
   // Clock
   input  wire logic        pclk,
   // APB request
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   // APB answer
   input  wire logic        pready
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus at time zero
   initial
   begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
   end

   // One transfer; request held until pready is seen high at a rising edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      pwdata  <= ~d;  // Released bus shows no stale word
   endtask
endmodule

// >>> testbench/tb_host_irq_mask_fifo_levels.sv
// Self-checking testbench for the interrupt gate, thresholds and receive config block
module tb_host_irq_mask_fifo_levels;
   import hifl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata, irq_status_word, seed, en;
   hifl_levels_s       fifo_levels;
   logic               rx_dword_read, irq_request, rx_dma_done;
   logic [11:0]        rx_pkt_dwords;
   hifl_level_irq_s    level_irqs;
   logic [3:0]         rx_pad_dwords;
   logic [3:0]         done_n = 4'h0;
   logic [32:0]        rdq[$];
   int                 fails, compares;

   hifl_irq_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .irq_status_word(irq_status_word), .fifo_levels(fifo_levels), .rx_dword_read(rx_dword_read),
      .rx_pkt_dwords(rx_pkt_dwords), .irq_request(irq_request), .level_irqs(level_irqs),
      .rx_dma_done(rx_dma_done), .rx_pad_dwords(rx_pad_dwords));
   hifl_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready));

   // 20 MHz clock
   always #25 pclk = ~pclk;

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic chk_word(input logic [32:0] got, input logic [32:0] exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bits(input logic [3:0] got, input logic [3:0] exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic complete_run;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Read notes the expected {error, data} before the transfer starts
   task automatic rd(input logic [7:0] a, input logic [32:0] exp);
      rdq.push_back(exp);
      host.xfer(1'b0, a, 32'h0000_0000);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d);
   endtask

   // Let inputs propagate through the registered paths, then sample settled outputs
   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   task automatic pulse_read;
      @(posedge pclk);
      rx_dword_read <= 1'b1;
      @(posedge pclk);
      rx_dword_read <= 1'b0;
   endtask

   // Read monitor takes the oldest note at each completed read
   always @(posedge pclk)
   begin
      if (psel && penable && !pwrite && pready === 1'b1)
         chk_word({pslverr, prdata}, rdq.pop_front());
      if (rx_dma_done === 1'b1)
         done_n <= done_n + 4'h1;
   end

   // Watchdog well beyond the expected run length
   initial
   begin
      #(50 * 20000);
      fails++;
      complete_run();
   end

   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      irq_status_word = 32'h0000_0000;
      fifo_levels = {8'h00, 8'h00, 8'hFF, 8'h00};  // No level event active
      rx_dword_read = 1'b0;
      rx_pkt_dwords = 12'd9;
      seed = 32'h0000_7002;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFF_IRQ_SOURCE_MASK, {1'b0, IRQ_MASK_RST});
      rd(OFF_BYTE_ORDER_PROBE, {1'b0, BYTE_ORDER_PATTERN});
      rd(OFF_FIFO_LEVEL_THRESH, {1'b0, FIFO_THRESH_RST});
      rd(OFF_RX_ENGINE_CONFIG, {1'b0, RX_CFG_RST});
      wr(OFF_BYTE_ORDER_PROBE, 32'h0000_0000);
      rd(OFF_BYTE_ORDER_PROBE, {1'b0, BYTE_ORDER_PATTERN});
      rd(8'h60, {1'b1, 32'h0000_0000});
      // Each enable bit alone gates only its own source; reserved bits stay zero
      for (int i = 0; i < 32; i++)
      begin
         en = 32'h1 << i;
         wr(OFF_IRQ_SOURCE_MASK, en);
         rd(OFF_IRQ_SOURCE_MASK, {1'b0, en & IRQ_MASK_WRITABLE});
         @(posedge pclk);
         irq_status_word <= ~en;
         settle(2);
         chk_bits({3'b000, irq_request}, 4'h0);
         @(posedge pclk);
         irq_status_word <= en;
         settle(2);
         chk_bits({3'b000, irq_request}, {3'b000, IRQ_MASK_WRITABLE[i]});
      end
      // Random enables and sources
      for (int k = 0; k < 12; k++)
      begin
         seed = xs(seed);
         en = seed & 32'hFFEF_FD57;  // Sources driven by internal events kept off
         wr(OFF_IRQ_SOURCE_MASK, en);
         seed = xs(seed);
         @(posedge pclk);
         irq_status_word <= seed;
         settle(2);
         chk_bits({3'b000, irq_request}, {3'b000, |(seed & en & IRQ_MASK_WRITABLE)});
      end
      @(posedge pclk);
      irq_status_word <= 32'h0000_0000;
      wr(OFF_IRQ_SOURCE_MASK, 32'h0000_0080);
      // Thresholds: strict compares on both sides of each boundary
      wr(OFF_FIFO_LEVEL_THRESH, 32'h1005_2003);
      rd(OFF_FIFO_LEVEL_THRESH, {1'b0, 32'h1005_2003});
      @(posedge pclk);
      fifo_levels <= {8'h11, 8'h05, 8'h1F, 8'h04};
      settle(3);
      chk_bits(level_irqs, 4'b1011);
      chk_bits({3'b000, irq_request}, 4'h0);
      @(posedge pclk);
      fifo_levels <= {8'h10, 8'h06, 8'h20, 8'h03};
      settle(3);
      chk_bits(level_irqs, 4'b0100);
      chk_bits({3'b000, irq_request}, 4'h1);
      @(posedge pclk);
      fifo_levels <= {8'h00, 8'h00, 8'hFF, 8'h00};
      // Countdown with an overwrite before zero and a read at zero
      wr(OFF_RX_ENGINE_CONFIG, 32'h0002_0000);
      pulse_read();
      wr(OFF_RX_ENGINE_CONFIG, 32'h0001_0000);  // Host overwrite with the packet half read
      pulse_read();
      pulse_read();
      settle(2);
      chk_bits(done_n, 4'h1);
      rd(OFF_RX_ENGINE_CONFIG, {1'b0, 32'h0000_0000});
      // Alignment changed only between packets, 9 DWORD packet
      for (int c = 0; c < 4; c++)
      begin
         wr(OFF_RX_ENGINE_CONFIG, 32'(c) << ALIGN_LSB);
         settle(2);
         chk_bits(rx_pad_dwords, (c == 1) ? 4'h3 : (c == 2) ? 4'h7 : 4'h0);
      end
      complete_run();
   end
endmodule
